// ---- rtl/msad_memory_space_address_decode.sv ----
// Program and data memory space decode with byte lanes and address error trap
// What this block does
// [R1] Program words are 24 bits: even lower word, odd upper word, top byte absent.
// [R2] Instruction pointer stays even and moves by two per instruction word.
// [R3] Fetch starts at zero after reset; start-of-code pointer lives at two.
// [R4] Two vector tables are reserved: 0x4 to 0xff and 0x100 to 0x1ff.
// [R5] Top three program words hold configuration, loaded on every reset.
// [R6] Configuration range ends at a size-dependent address per memory variant.
// [R7] Stored configuration bits are remapped into registers in different order.
// [R8] Data space is linear 16-bit words with separate read and write generators.
// [R9] Byte addresses are 16 bits; bit 15 selects the program window.
// [R10] Only 16 Kbytes implemented; reads outside return zero.
// [R11] Even byte address is the low byte, odd is the high byte.
// [R12] Post-increment steps the pointer by one for bytes, two for words.
// [R13] Byte read takes the whole word, picks by bit zero, returns it low.
// [R14] Shared word decode, per-lane write strobes; byte writes touch one lane.
// [R15] Word write to an odd address is refused; any odd word access raises an address trap.
// [R16] Misaligned read completes first; misaligned write is suppressed; then trap.
// [R17] Byte load to a working register changes only its low byte.
// [R18] Sign-widen and upper-clear operations on working register data.
// [R19] Near region 0 to 0x1fff reached by a 13-bit direct field.
// [R20] Move instructions reach the whole space with a 16-bit field.
// [R21] Special register area 0 to 0x7ff reads zero where unimplemented.
// [R22] Window enable bit clear hides program memory from the upper half; the block reads zero there with the bit set as well.
// [R23] Address error trap pulses one cycle after the instruction's effects.
// [R24] Same-word read and write in one cycle: read sees the old value.
`timescale 1ns/1ps
`include "msad_defines.svh"
module msad_memory_space_address_decode #(
    parameter int PROG_WORDS = 87552,
    parameter int RAM_BYTES = 16384,
    parameter logic [22:0] CFG_END = `MSAD_CFG_END_LARGE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instruction pointer control
    input wire logic step_fwd,
    input wire logic step_back,
    input wire logic load_ptr,
    input wire logic [22:0] load_value,
    output logic [22:0] instruction_pointer,
    output logic in_vector_area,
    output logic in_alt_vector_area,
    // Program memory port
    output logic [22:0] prog_addr,
    input wire logic [23:0] prog_rdata,
    // Configuration loading
    output logic cfg_busy,
    output logic [23:0] cfg_reg0,
    output logic [23:0] cfg_reg1,
    output logic [23:0] cfg_reg2,
    // Data read and write requests
    input wire msad_pkg::msad_req_t rd_req,
    input wire msad_pkg::msad_req_t wr_req,
    input wire logic [15:0] wr_data,
    input wire logic program_window_enable,
    input wire logic instr_end,
    // Data read result and pointer updates
    output logic [15:0] rd_data,
    output logic [15:0] rd_nxt_pointer,
    output logic [15:0] wr_nxt_pointer,
    // Special register area interface
    output logic [15:0] special_addr,
    output logic [1:0] special_we,
    input wire logic [15:0] special_rdata,
    input wire logic special_hit,
    // Working register byte/extend path
    input wire logic [15:0] wreg_old,
    input wire msad_pkg::msad_ext_t ext_op,
    output logic [15:0] wreg_new,
    // Trap
    output logic address_error_trap
);
    import msad_pkg::*;
    localparam int RAM_WORDS = RAM_BYTES / 2;
    localparam int RAM_AW = $clog2(RAM_WORDS);
    initial begin
        if (RAM_BYTES > 32768 || RAM_BYTES < 4096) $error("RAM_BYTES out of range");
        if (PROG_WORDS < 8) $error("PROG_WORDS too small");
    end

    logic [15:0] ram_lo [RAM_WORDS];
    logic [15:0] rd_ea, wr_ea;
    logic rd_mis, wr_mis, rd_ram, wr_ram, rd_win, wr_win, rd_spec, wr_spec;
    logic [22:0] ip_ff;
    logic [15:0] rd_data_ff;
    // Size of the last taken read, so the merge does not follow a later request
    logic rd_byte_ff;
    logic trap_pend_ff, trap_ff;
    msad_cfg_state_t cfg_state_ff;
    logic [1:0] cfg_idx_ff;
    logic [23:0] cfg_raw0_ff, cfg_raw1_ff, cfg_raw2_ff;

    msad_address_generation_unit u_rd_agu ( // see [R8]
        .req(rd_req),
        .effective_address(rd_ea),
        .nxt_pointer(rd_nxt_pointer),
        .misaligned(rd_mis),
        .in_ram(rd_ram),
        .in_window(rd_win),
        .in_special(rd_spec)
    );
    msad_address_generation_unit u_wr_agu ( // see [R8]
        .req(wr_req),
        .effective_address(wr_ea),
        .nxt_pointer(wr_nxt_pointer),
        .misaligned(wr_mis),
        .in_ram(wr_ram),
        .in_window(wr_win),
        .in_special(wr_spec)
    );

    // Instruction pointer, always even
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ip_ff <= `MSAD_RESET_VECTOR; // see [R3]
        end else if (cfg_state_ff != MSAD_CFG_DONE) begin
            ip_ff <= `MSAD_RESET_VECTOR;
        end else if (load_ptr) begin
            ip_ff <= {load_value[22:1], 1'b0}; // see [R2]
        end else if (step_fwd) begin
            ip_ff <= ip_ff + `MSAD_PC_STEP; // see [R2]
        end else if (step_back) begin
            ip_ff <= ip_ff - `MSAD_PC_STEP;
        end
    end
    assign instruction_pointer = ip_ff;
    // see [R4]
    assign in_vector_area = ip_ff >= `MSAD_IVT_LO && ip_ff <= `MSAD_IVT_HI;
    assign in_alt_vector_area = ip_ff >= `MSAD_AIVT_LO && ip_ff <= `MSAD_AIVT_HI;

    // Configuration loader: walks top three words after every reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_state_ff <= MSAD_CFG_IDLE;
            cfg_idx_ff <= 2'h0;
        end else begin
            case (cfg_state_ff)
                MSAD_CFG_IDLE: cfg_state_ff <= MSAD_CFG_LOAD; // see [R5]
                MSAD_CFG_LOAD: begin
                    if (cfg_idx_ff == 2'(`MSAD_CFG_WORDS)) begin
                        cfg_state_ff <= MSAD_CFG_DONE;
                    end
                    cfg_idx_ff <= cfg_idx_ff + 2'h1;
                end
                MSAD_CFG_DONE: cfg_state_ff <= MSAD_CFG_DONE;
                default: cfg_state_ff <= MSAD_CFG_IDLE;
            endcase
        end
    end
    // Word k sits 2*(2-k) below the end, lowest word first; see [R6]
    always_comb begin
        prog_addr = ip_ff;
        if (cfg_state_ff != MSAD_CFG_DONE) begin
            prog_addr = CFG_END - 23'(2 * (`MSAD_CFG_WORDS - cfg_idx_ff));
        end
    end
    // Memory answers combinationally, so capture this cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_raw0_ff <= 24'h0;
            cfg_raw1_ff <= 24'h0;
            cfg_raw2_ff <= 24'h0;
        end else if (cfg_state_ff == MSAD_CFG_LOAD) begin
            case (cfg_idx_ff)
                2'h0: cfg_raw0_ff <= {8'h0, prog_rdata[15:0]}; // see [R1]
                2'h1: cfg_raw1_ff <= {8'h0, prog_rdata[15:0]};
                2'h2: cfg_raw2_ff <= {8'h0, prog_rdata[15:0]};
                default: cfg_raw0_ff <= cfg_raw0_ff;
            endcase
        end
    end
    // Packed store order is byte-swapped into the live registers; see [R7]
    assign cfg_reg0 = {8'h0, cfg_raw0_ff[7:0], cfg_raw0_ff[15:8]};
    assign cfg_reg1 = {8'h0, cfg_raw1_ff[7:0], cfg_raw1_ff[15:8]};
    assign cfg_reg2 = {8'h0, cfg_raw2_ff[7:0], cfg_raw2_ff[15:8]};
    assign cfg_busy = cfg_state_ff != MSAD_CFG_DONE;

    // Data write: per-lane strobes, misaligned word writes dropped
    logic wr_go;
    logic [1:0] wr_lanes;
    logic [15:0] wr_lane_data;
    assign wr_go = wr_req.valid && !wr_mis && !cfg_busy; // see [R16]
    always_comb begin
        wr_lanes = 2'h3;
        wr_lane_data = wr_data;
        if (wr_req.is_byte) begin
            wr_lanes = wr_ea[0] ? 2'h2 : 2'h1; // see [R14]
            wr_lane_data = {wr_data[7:0], wr_data[7:0]}; // see [R11]
        end
    end
    always_ff @(posedge clk) begin
        if (wr_go && wr_ram && !wr_spec) begin
            if (wr_lanes[0]) begin
                ram_lo[wr_ea[RAM_AW:1]][7:0] <= wr_lane_data[7:0]; // see [R14]
            end
            if (wr_lanes[1]) begin
                ram_lo[wr_ea[RAM_AW:1]][15:8] <= wr_lane_data[15:8];
            end
        end
    end
    assign special_addr = wr_req.valid ? wr_ea : rd_ea;
    assign special_we = (wr_go && wr_spec) ? wr_lanes : 2'h0;

    // Data read: old value wins on same-word collision (registered read)
    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0; // see [R10]
        if (rd_spec) begin
            rd_word = special_hit ? special_rdata : 16'h0; // see [R21]
        end else if (rd_ram) begin
            rd_word = ram_lo[rd_ea[RAM_AW:1]]; // see [R24]
        end else if (rd_win && program_window_enable) begin
            rd_word = 16'h0; // see [R22]
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= 16'h0;
            rd_byte_ff <= 1'b0;
        end else if (rd_req.valid) begin
            rd_byte_ff <= rd_req.is_byte;
            if (rd_req.is_byte) begin
                rd_data_ff <= {8'h0, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]}; // see [R13]
            end else begin
                rd_data_ff <= rd_word;
            end
        end
    end
    assign rd_data = rd_data_ff;

    // Working register merge
    always_comb begin
        wreg_new = rd_data_ff;
        case (ext_op)
            MSAD_EXT_SIGN: wreg_new = {{8{wreg_old[7]}}, wreg_old[7:0]}; // see [R18]
            MSAD_EXT_ZERO: wreg_new = {8'h0, wreg_old[7:0]}; // see [R18]
            default: wreg_new = rd_byte_ff ? {wreg_old[15:8], rd_data_ff[7:0]}
                : rd_data_ff; // see [R17]
        endcase
    end

    // Trap held until the instruction ends, then one pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap_pend_ff <= 1'b0;
            trap_ff <= 1'b0;
        end else begin
            trap_ff <= 1'b0;
            if (instr_end && (trap_pend_ff || rd_mis || wr_mis)) begin
                trap_ff <= 1'b1; // see [R23]
                trap_pend_ff <= 1'b0;
            end else if (rd_mis || wr_mis) begin
                trap_pend_ff <= 1'b1; // see [R15] [R16]
            end
        end
    end
    assign address_error_trap = trap_ff;
endmodule

// ---- rtl/msad_defines.svh ----
// Constants for the memory space address decode block
`ifndef MSAD_DEFINES_SVH
`define MSAD_DEFINES_SVH
`define MSAD_RESET_VECTOR 23'h000000
`define MSAD_START_SLOT 23'h000002
`define MSAD_IVT_LO 23'h000004
`define MSAD_IVT_HI 23'h0000ff
`define MSAD_AIVT_LO 23'h000100
`define MSAD_AIVT_HI 23'h0001ff
`define MSAD_PC_STEP 23'h000002
`define MSAD_CFG_WORDS 2
`define MSAD_CFG_END_SMALL 23'h00abfe
`define MSAD_CFG_END_MID 23'h0157fe
`define MSAD_CFG_END_LARGE 23'h02abfe
`define MSAD_DATA_BYTES 16'h4000
`define MSAD_NEAR_TOP 16'h1fff
`define MSAD_SPECIAL_TOP 16'h07ff
`define MSAD_WINDOW_BIT 15
`define MSAD_BYTE_STEP 16'h0001
`define MSAD_WORD_STEP 16'h0002
`endif

// ---- rtl/msad_pkg.sv ----
// Types shared by the memory space address decode block
package msad_pkg;
    typedef enum logic [1:0] {
        MSAD_AM_DIRECT13 = 2'h0,
        MSAD_AM_DIRECT16 = 2'h1,
        MSAD_AM_INDIRECT = 2'h2,
        MSAD_AM_POSTINC = 2'h3
    } msad_amode_t;
    typedef enum logic [1:0] {
        MSAD_EXT_NONE = 2'h0,
        MSAD_EXT_SIGN = 2'h1,
        MSAD_EXT_ZERO = 2'h2
    } msad_ext_t;
    typedef struct packed {
        logic valid;
        logic is_byte;
        msad_amode_t mode;
        logic [15:0] field;
        logic [15:0] source_pointer_reg;
    } msad_req_t;
    typedef enum logic [2:0] {
        MSAD_CFG_IDLE = 3'h1,
        MSAD_CFG_LOAD = 3'h2,
        MSAD_CFG_DONE = 3'h4
    } msad_cfg_state_t;
endpackage

// ---- rtl/msad_address_generation_unit.sv ----
// One data-space address generator: forms the effective address and decodes it
`timescale 1ns/1ps
`include "msad_defines.svh"
module msad_address_generation_unit (
    // Request from the core
    input wire msad_pkg::msad_req_t req,
    // Decoded address
    output logic [15:0] effective_address,
    output logic [15:0] nxt_pointer,
    output logic misaligned,
    output logic in_ram,
    output logic in_window,
    output logic in_special
);
    import msad_pkg::*;
    always_comb begin
        effective_address = req.field;
        case (req.mode)
            MSAD_AM_DIRECT13: effective_address = {3'h0, req.field[12:0]}; // see [R19]
            MSAD_AM_DIRECT16: effective_address = req.field; // see [R20]
            MSAD_AM_INDIRECT: effective_address = req.source_pointer_reg;
            MSAD_AM_POSTINC: effective_address = req.source_pointer_reg;
            default: effective_address = req.field;
        endcase
        nxt_pointer = req.source_pointer_reg;
        if (req.mode == MSAD_AM_POSTINC) begin
            nxt_pointer = req.source_pointer_reg +
                (req.is_byte ? `MSAD_BYTE_STEP : `MSAD_WORD_STEP); // see [R12]
        end
    end
    assign misaligned = req.valid && !req.is_byte && effective_address[0]; // see [R15]
    assign in_window = effective_address[`MSAD_WINDOW_BIT]; // see [R9]
    assign in_ram = !in_window && (effective_address < `MSAD_DATA_BYTES); // see [R10]
    assign in_special = effective_address <= `MSAD_SPECIAL_TOP; // see [R21]
endmodule

// ---- dv/msad_memory_space_address_decode_monitor.sv ----
// Checker for the memory space address decode block
`timescale 1ns/1ps
module msad_memory_space_address_decode_monitor #(
    parameter logic [22:0] CFG_END = 23'h02abfe
) (
    // Clock, reset and pointer
    input wire logic clk,
    input wire logic nrst,
    input wire logic step_fwd,
    input wire logic step_back,
    input wire logic load_ptr,
    input wire logic instr_end,
    input wire logic [22:0] instruction_pointer,
    input wire logic in_vector_area,
    input wire logic [22:0] prog_addr,
    input wire logic cfg_busy,
    // Data write side and trap
    input wire msad_pkg::msad_req_t wr_req,
    input wire logic [1:0] special_we,
    input wire logic address_error_trap
);
    import msad_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ptr_even_a: assert property (!instruction_pointer[0]) else $error("pointer odd");
    ptr_step_a: assert property (step_fwd && !step_back && !load_ptr && !cfg_busy
        |=> instruction_pointer == $past(instruction_pointer) + 23'h2) else $error("bad step");
    reset_fetch_a: assert property ($fell(cfg_busy) |-> instruction_pointer == 23'h0)
        else $error("fetch not at zero");
    vector_area_a: assert property (in_vector_area ==
        (instruction_pointer inside {[23'h4:23'hff]})) else $error("vector area wrong");
    cfg_end_a: assert property ($fell(cfg_busy) |-> $past(prog_addr) == CFG_END)
        else $error("config range wrong");
    trap_pulse_a: assert property (address_error_trap |=> !address_error_trap)
        else $error("trap too long");
    trap_cause_a: assert property (address_error_trap |-> $past(instr_end))
        else $error("trap before end");
    lane_strobe_a: assert property (wr_req.valid && wr_req.mode == MSAD_AM_DIRECT16 &&
        wr_req.field < 16'h0800 && !cfg_busy |-> special_we == (!wr_req.is_byte ?
        (wr_req.field[0] ? 2'h0 : 2'h3) : (wr_req.field[0] ? 2'h2 : 2'h1)))
        else $error("lane strobe wrong");
    cover property ($fell(cfg_busy));
    cover property (address_error_trap);
    cover property (wr_req.valid && wr_req.is_byte && special_we != 2'h0);
endmodule
bind msad_memory_space_address_decode msad_memory_space_address_decode_monitor #(
    .CFG_END(CFG_END)) u_mon (.clk, .nrst, .step_fwd, .step_back, .load_ptr, .instr_end,
    .instruction_pointer, .in_vector_area, .prog_addr, .cfg_busy, .wr_req, .special_we,
    .address_error_trap);

// ---- dv/msad_far_side_model.sv ----
// Far-side model: program memory and a small special register area
`timescale 1ns/1ps
module msad_far_side_model (
    // Clock
    input wire logic clk,
    // Program memory
    input wire logic [22:0] prog_addr,
    output logic [23:0] prog_rdata,
    // Special register area
    input wire logic [15:0] special_addr,
    input wire logic [1:0] special_we,
    input wire logic [15:0] wr_data,
    output logic [15:0] special_rdata,
    output logic special_hit
);
    logic [15:0] regs_ff [0:127];
    // Full 24-bit word, pattern traceable to its address
    assign prog_rdata = {prog_addr[7:0] ^ 8'h5a, prog_addr[15:0]};
    // Only the first 256 bytes exist; misses drive junk the block must hide
    assign special_hit = special_addr < 16'h0100;
    assign special_rdata = special_hit ? regs_ff[special_addr[7:1]] : 16'hffff;
    always_ff @(posedge clk) begin
        if (special_hit && special_we[0]) regs_ff[special_addr[7:1]][7:0] <= wr_data[7:0];
        if (special_hit && special_we[1]) regs_ff[special_addr[7:1]][15:8] <= wr_data[15:8];
    end
endmodule

// ---- dv/test_memory_space_address_decode.sv ----
// Self-checking bench for the memory space address decode block
`timescale 1ns/1ps
`include "msad_defines.svh"
module test_memory_space_address_decode;
    import msad_pkg::*;
    localparam logic [22:0] CE = `MSAD_CFG_END_SMALL;
    localparam msad_req_t IDLE = '0;
    logic clk = 1'b0, nrst = 1'b0, step_fwd = 1'b0, step_back = 1'b0, load_ptr = 1'b0;
    logic program_window_enable = 1'b0, instr_end = 1'b0, cfg_busy, special_hit;
    logic in_vector_area, in_alt_vector_area, address_error_trap;
    logic [22:0] load_value = 23'h0, instruction_pointer, prog_addr;
    logic [23:0] prog_rdata, cfg_reg0, cfg_reg1, cfg_reg2;
    msad_req_t rd_req = '0, wr_req = '0, r;
    msad_ext_t ext_op = MSAD_EXT_NONE;
    logic [15:0] wr_data = 16'h0, wreg_old = 16'h1280, wreg_new, rd_data, a, special_rdata;
    logic [15:0] rd_nxt_pointer, wr_nxt_pointer, special_addr;
    logic [1:0] special_we;
    logic [31:0] seed = 32'h00012d05;
    logic [22:0] lv [6] = '{23'h3, 23'h4, 23'hff, 23'h100, 23'h1ff, 23'h200};
    int fail_count = 0, n_checks = 0;
    always #4 clk = ~clk;
    msad_memory_space_address_decode #(.PROG_WORDS(22016), .CFG_END(CE)) uut (.clk, .nrst,
        .step_fwd, .step_back, .load_ptr, .load_value, .instruction_pointer, .in_vector_area,
        .in_alt_vector_area, .prog_addr, .prog_rdata, .cfg_busy, .cfg_reg0, .cfg_reg1,
        .cfg_reg2, .rd_req, .wr_req, .wr_data, .program_window_enable, .instr_end, .rd_data,
        .rd_nxt_pointer, .wr_nxt_pointer, .special_addr, .special_we, .special_rdata,
        .special_hit, .wreg_old, .ext_op, .wreg_new, .address_error_trap);
    msad_far_side_model u_far (.clk, .prog_addr, .prog_rdata, .special_addr, .special_we,
        .wr_data, .special_rdata, .special_hit);
    function automatic logic [31:0] xorshift(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [15:0] bsel(logic [15:0] w, logic a0);
        return a0 ? {8'h0, w[15:8]} : {8'h0, w[7:0]};
    endfunction
    function automatic logic [23:0] cfgx(logic [22:0] p);
        return {8'h0, p[7:0], p[15:8]};
    endfunction
    function automatic msad_req_t mk(logic b, logic [15:0] ad);
        return '{1'b1, b, MSAD_AM_DIRECT16, ad, 16'h0};
    endfunction
    task automatic chk(logic [23:0] seen, logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(msad_req_t rq, msad_req_t wq, logic [15:0] d = 16'h0, logic e = 1'b0);
        @(posedge clk);
        #1;
        rd_req = rq;
        wr_req = wq;
        wr_data = d;
        instr_end = e;
    endtask
    task automatic rd(logic b, logic [15:0] ad, logic [15:0] exp);
        cyc(mk(b, ad), IDLE);
        cyc(IDLE, IDLE);
        chk({8'h0, rd_data}, {8'h0, exp});
    endtask
    task automatic wr(logic b, logic [15:0] ad, logic [15:0] d);
        cyc(IDLE, mk(b, ad), d);
        cyc(IDLE, IDLE);
    endtask
    task automatic ptr(logic f, logic b, logic l, logic [22:0] v);
        @(posedge clk);
        #1;
        {step_fwd, step_back, load_ptr, load_value} = {f, b, l, v};
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        for (int i = 0; i < 20 && cfg_busy !== 1'b0; i++) @(posedge clk);
        cyc(IDLE, IDLE);
        chk({1'b0, instruction_pointer}, 24'h0);
        chk(cfg_reg0, cfgx(CE - 23'h4));
        chk(cfg_reg1, cfgx(CE - 23'h2));
        chk(cfg_reg2, cfgx(CE));
        $display("test reset done");
        foreach (lv[i]) begin
            ptr(1'b0, 1'b0, 1'b1, lv[i]);
            ptr(1'b0, 1'b0, 1'b0, 23'h0);
            a = {lv[i][15:1], 1'b0};
            chk({in_alt_vector_area, in_vector_area, instruction_pointer[21:0]},
                {a inside {[16'h100:16'h1ff]}, a inside {[16'h4:16'hff]}, 6'h0, a});
        end
        ptr(1'b1, 1'b0, 1'b0, 23'h0);
        ptr(1'b0, 1'b1, 1'b0, 23'h0);
        chk({1'b0, instruction_pointer}, 24'h000202);
        ptr(1'b0, 1'b0, 1'b0, 23'h0);
        chk({1'b0, instruction_pointer}, 24'h000200);
        $display("test pointer done");
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            a = 16'h0800 + (seed[15:0] & 16'h37fe);
            wr(1'b0, a, seed[31:16]);
            rd(1'b0, a, seed[31:16]);
            rd(1'b1, a | {15'h0, seed[16]}, bsel(seed[31:16], seed[16]));
        end
        wr(1'b0, 16'h0a02, 16'h1234);
        wr(1'b1, 16'h0a03, 16'habab);
        rd(1'b0, 16'h0a02, 16'hab34);
        rd(1'b1, 16'h0a03, 16'h00ab);
        chk({8'h0, wreg_new}, 24'h0012ab);
        ext_op = MSAD_EXT_SIGN;
        #1 chk({8'h0, wreg_new}, 24'h00ff80);
        cyc(IDLE, IDLE);
        ext_op = MSAD_EXT_ZERO;
        #1 chk({8'h0, wreg_new}, 24'h000080);
        wr(1'b0, 16'h0c00, 16'h1111);
        cyc(mk(1'b0, 16'h0c00), mk(1'b0, 16'h0c00), 16'h2222);
        cyc(IDLE, IDLE);
        chk({8'h0, rd_data}, 24'h001111);
        rd(1'b0, 16'h0c00, 16'h2222);
        for (int b = 0; b < 2; b++) begin
            r = '{1'b1, b[0], MSAD_AM_POSTINC, 16'h0, 16'h0a02};
            cyc(r, r);
            #1 chk({8'h0, rd_nxt_pointer}, b ? 24'h000a03 : 24'h000a04);
            chk({8'h0, wr_nxt_pointer}, b ? 24'h000a03 : 24'h000a04);
        end
        $display("test data done");
        wr(1'b0, 16'h0040, 16'h1234);
        wr(1'b1, 16'h0041, 16'h5a5a);
        rd(1'b0, 16'h0040, 16'h5a34);
        rd(1'b0, 16'h0600, 16'h0000);
        cyc('{1'b1, 1'b0, MSAD_AM_DIRECT13, 16'he040, 16'h0}, IDLE);
        cyc(IDLE, IDLE);
        chk({8'h0, rd_data}, 24'h005a34);
        rd(1'b0, 16'h4000, 16'h0000);
        rd(1'b1, 16'h7fff, 16'h0000);
        program_window_enable = 1'b1;
        rd(1'b0, 16'h8000, 16'h0000);
        $display("test regions done");
        cyc(IDLE, mk(1'b0, 16'h0041), 16'hffff, 1'b1);
        cyc(IDLE, IDLE);
        chk({23'h0, address_error_trap}, 24'h1);
        cyc(mk(1'b0, 16'h0a03), IDLE);
        chk({23'h0, address_error_trap}, 24'h0);
        cyc(IDLE, IDLE);
        chk({23'h0, address_error_trap}, 24'h0);
        cyc(IDLE, IDLE, 16'h0, 1'b1);
        cyc(IDLE, IDLE);
        chk({23'h0, address_error_trap}, 24'h1);
        rd(1'b0, 16'h0040, 16'h5a34);
        $display("test trap done");
        final_report();
    end
endmodule
